// ==== hw/drive_command_source_select.sv ====
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "drive_select_consts.svh"
module drive_command_source_select
  import drive_select_pkg::*;
#(
  parameter int unsigned PULSE_GATE_CYCLES = `PULSE_GATE_NS / `CLK_PERIOD_NS
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  programmable_inputs,
  input  wire logic        keypad_run_key,
  input  wire logic        stop_key,
  input  wire logic        up_request,
  input  wire logic        down_request,
  input  wire logic        drive_running,
  input  wire logic        drive_stalling,
  input  wire logic [15:0] stage_frequency,
  input  wire logic [11:0] first_analog_channel,
  input  wire logic [11:0] second_analog_channel,
  input  wire logic [11:0] panel_knob_voltage,
  output logic             run_command,
  output logic             reverse_command,
  output logic             ramp_stop,
  output logic             immediate_stop,
  output logic             emergency_stop_error_code,
  output logic [15:0]      speed_reference,
  output logic             store_request,
  output logic [15:0]      store_value
);

  ////////////////////////////////////////////////////////////////////////////////
  // settings and apb slave
  logic [1:0]  command_source_select;
  logic [1:0]  stop_key_scope;
  logic [2:0]  terminal_wiring_scheme;
  logic        keypad_direction_setting;
  logic [3:0]  speed_reference_source;
  logic [2:0]  ahead_idx;
  logic [2:0]  backward_idx;
  logic [2:0]  hold_idx;
  logic [7:0]  binary_mask;
  logic [4:0]  first_terminal_function;
  logic [6:0]  first_analog_gain;
  logic [6:0]  second_analog_gain;
  freq_t       max_frequency;
  freq_t       digital_frequency;
  freq_t       step_size;
  logic        remote_run;
  logic        remote_reverse;
  logic        stop_latched;
  logic        wr_en;
  logic        addr_ok;

  assign pready  = ce;
  assign wr_en   = psel & penable & pwrite & ce;
  assign addr_ok = (paddr == `ADDR_SELECT) || (paddr == `ADDR_TERM_MAP)
                || (paddr == `ADDR_GAINS) || (paddr == `ADDR_MAX_FREQ)
                || (paddr == `ADDR_DIGITAL_FREQ) || (paddr == `ADDR_REMOTE_CMD)
                || (paddr == `ADDR_STATUS) || (paddr == `ADDR_STEP);
  assign pslverr = psel & penable & ~addr_ok;

  // each field is checked alone so one bad field does not block the rest
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      command_source_select    <= 2'h0;
      stop_key_scope           <= 2'h0;
      terminal_wiring_scheme   <= 3'h0;
      keypad_direction_setting <= 1'b0;
      speed_reference_source   <= 4'h0;
    end else if (ce && wr_en && paddr == `ADDR_SELECT && pstrb[0] && pstrb[1]) begin
      if (pwdata[1:0] <= 2'(`CMD_SRC_MAX))    command_source_select  <= pwdata[1:0];
      if (pwdata[3:2] <= 2'(`STOP_SCOPE_MAX)) stop_key_scope         <= pwdata[3:2];
      if (pwdata[6:4] <= 3'(`WIRING_MAX))     terminal_wiring_scheme <= pwdata[6:4];
      keypad_direction_setting <= pwdata[7];
      if (pwdata[11:8] <= 4'(`SPEED_SRC_MAX)) speed_reference_source <= pwdata[11:8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ahead_idx               <= 3'h0;
      backward_idx            <= 3'h1;
      hold_idx                <= 3'h2;
      binary_mask             <= 8'h00;
      first_terminal_function <= 5'h00;
    end else if (ce && wr_en && paddr == `ADDR_TERM_MAP && (&pstrb)) begin
      ahead_idx               <= pwdata[2:0];
      backward_idx            <= pwdata[6:4];
      hold_idx                <= pwdata[10:8];
      binary_mask             <= pwdata[23:16];
      first_terminal_function <= pwdata[28:24];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      first_analog_gain  <= `GAIN_RESET;
      second_analog_gain <= `GAIN_RESET;
      max_frequency      <= `MAX_FREQ_RESET;
      step_size          <= `STEP_RESET;
    end else if (ce && wr_en) begin
      if (paddr == `ADDR_GAINS && pwdata[6:0] <= 7'(`GAIN_MAX) && pstrb[0])
        first_analog_gain <= pwdata[6:0];
      if (paddr == `ADDR_GAINS && pwdata[14:8] <= 7'(`GAIN_MAX) && pstrb[1])
        second_analog_gain <= pwdata[14:8];
      if (paddr == `ADDR_MAX_FREQ && pstrb[0] && pstrb[1])
        max_frequency <= pwdata[15:0];
      if (paddr == `ADDR_STEP && pstrb[0] && pstrb[1])
        step_size <= pwdata[15:0];
    end
  end

  // remote computer writes its run and direction through this register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      remote_run     <= 1'b0;
      remote_reverse <= 1'b0;
    end else if (ce && wr_en && paddr == `ADDR_REMOTE_CMD && pstrb[0]) begin
      remote_run     <= pwdata[0];
      remote_reverse <= pwdata[1];
    end
  end

  // read data is captured in the setup cycle, so it is ready at the access edge
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      unique case (paddr)
        `ADDR_SELECT:       prdata <= {20'h0_0000, speed_reference_source,
                                       keypad_direction_setting, terminal_wiring_scheme,
                                       stop_key_scope, command_source_select};
        `ADDR_TERM_MAP:     prdata <= {3'h0, first_terminal_function, binary_mask, 5'h00,
                                       hold_idx, 1'b0, backward_idx, 1'b0, ahead_idx};
        `ADDR_GAINS:        prdata <= {17'h0_0000, second_analog_gain, 1'b0, first_analog_gain};
        `ADDR_MAX_FREQ:     prdata <= {16'h0000, max_frequency};
        `ADDR_DIGITAL_FREQ: prdata <= {16'h0000, digital_frequency};
        `ADDR_REMOTE_CMD:   prdata <= {30'h0000_0000, remote_reverse, remote_run};
        `ADDR_STATUS:       prdata <= {speed_reference, 12'h000, stop_latched,
                                       emergency_stop_error_code, reverse_command, run_command};
        `ADDR_STEP:         prdata <= {16'h0000, step_size};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // terminal input conditioning
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] terminals;
  logic [7:0] terminals_prev;

  // a bit moves only once the second and third stage agree
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync1          <= 8'h00;
      sync2          <= 8'h00;
      sync3          <= 8'h00;
      terminals      <= 8'h00;
      terminals_prev <= 8'h00;
    end else if (ce) begin
      sync1          <= programmable_inputs;
      sync2          <= sync1;
      sync3          <= sync2;
      terminals      <= (sync2 & sync3) | (terminals & (sync2 ^ sync3));
      terminals_prev <= terminals;
    end
  end

  logic ahead_lvl;
  logic backward_lvl;
  logic hold_lvl;
  logic ahead_rise;
  logic backward_rise;
  assign ahead_lvl     = terminals[ahead_idx];
  assign backward_lvl  = terminals[backward_idx];
  assign hold_lvl      = terminals[hold_idx];
  assign ahead_rise    = ahead_lvl & ~terminals_prev[ahead_idx];
  assign backward_rise = backward_lvl & ~terminals_prev[backward_idx];

  ////////////////////////////////////////////////////////////////////////////////
  // stop key scope
  cmd_source_t source;
  logic        key_honoured;
  logic        key_hard;
  logic        stall_stop;
  logic        key_event;
  assign source = cmd_source_t'(command_source_select);

  always_comb begin
    key_honoured = 1'b0;
    key_hard     = 1'b0;
    unique case (source)
      SRC_KEYPAD:   key_honoured = 1'b1;
      SRC_TERMINAL: begin
        key_honoured = (stop_key_scope == 2'h1)
                    || (stop_key_scope == 2'h2 && terminal_wiring_scheme >= 3'h2);
        key_hard     = (stop_key_scope == 2'h1);
      end
      SRC_REMOTE:   begin
        key_honoured = (stop_key_scope != 2'h0);
        key_hard     = (stop_key_scope == 2'h1);
      end
      default:      key_honoured = 1'b0;
    endcase
  end

  assign stall_stop = stop_key & drive_running & drive_stalling;
  assign key_event  = stop_key & drive_running & key_honoured;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ramp_stop      <= 1'b0;
      immediate_stop <= 1'b0;
    end else if (ce) begin
      ramp_stop      <= key_event & ~key_hard & ~stall_stop;
      immediate_stop <= (key_event & key_hard) | stall_stop;
    end
  end

  // sticky; a new stop event wins over a software clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      emergency_stop_error_code <= 1'b0;
    end else if (ce) begin
      if ((key_event & key_hard) | stall_stop)
        emergency_stop_error_code <= 1'b1;
      else if (wr_en && paddr == `ADDR_STATUS && pstrb[0] && pwdata[`STATUS_ESTOP_BIT])
        emergency_stop_error_code <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // run and direction from the chosen source
  logic keypad_run;
  logic term_run;
  logic term_rev;
  logic src_run;
  logic src_rev;
  logic lvl_run;
  logic lvl_rev;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      keypad_run <= 1'b0;
    end else if (ce) begin
      if (key_event | stall_stop)
        keypad_run <= 1'b0;
      else if (keypad_run_key && source == SRC_KEYPAD)
        keypad_run <= 1'b1;
    end
  end

  // latched schemes: three-line types and direction pulse
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      term_run <= 1'b0;
      term_rev <= 1'b0;
    end else if (ce) begin
      if (key_event | stall_stop) begin
        term_run <= 1'b0;
      end else begin
        unique case (terminal_wiring_scheme)
          3'h2: begin
            if (!hold_lvl) term_run <= 1'b0;
            else if (ahead_rise) begin
              term_run <= 1'b1;
              term_rev <= 1'b0;
            end else if (backward_rise) begin
              term_run <= 1'b1;
              term_rev <= 1'b1;
            end
          end
          3'h3: begin
            if (!hold_lvl) term_run <= 1'b0;
            else if (ahead_rise) term_run <= 1'b1;
            term_rev <= backward_lvl;
          end
          3'h4: begin
            if (ahead_rise) begin
              term_run <= ~(term_run & ~term_rev);
              term_rev <= 1'b0;
            end else if (backward_rise) begin
              term_run <= ~(term_run & term_rev);
              term_rev <= 1'b1;
            end
          end
          default: term_run <= 1'b0;
        endcase
      end
    end
  end

  always_comb begin
    lvl_run = 1'b0;
    lvl_rev = 1'b0;
    unique case (terminal_wiring_scheme)
      3'h0: begin
        lvl_run = ahead_lvl ^ backward_lvl;
        lvl_rev = backward_lvl;
      end
      3'h1: begin
        lvl_run = ahead_lvl;
        lvl_rev = backward_lvl;
      end
      default: begin
        lvl_run = term_run;
        lvl_rev = term_rev;
      end
    endcase
  end

  always_comb begin
    src_run = 1'b0;
    src_rev = 1'b0;
    unique case (source)
      SRC_KEYPAD: begin
        src_run = keypad_run;
        src_rev = keypad_direction_setting;
      end
      SRC_TERMINAL: begin
        src_run = lvl_run;
        src_rev = lvl_rev;
      end
      SRC_REMOTE: begin
        src_run = remote_run;
        src_rev = remote_reverse;
      end
      default: src_run = 1'b0;
    endcase
  end

  // a stopped level source must let go before it can run again
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stop_latched <= 1'b0;
    end else if (ce) begin
      if (key_event | stall_stop) stop_latched <= 1'b1;
      else if (!src_run) stop_latched <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      run_command     <= 1'b0;
      reverse_command <= 1'b0;
    end else if (ce) begin
      run_command     <= src_run & ~stop_latched & ~(key_event | stall_stop);
      reverse_command <= src_rev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // digital frequency, stage trim, pulse rate
  speed_source_t     spd;
  logic [16:0]       up_sum;
  logic signed [17:0] trim;
  logic signed [17:0] stage_sum;
  logic [31:0]       gate_count;
  logic [15:0]       pulse_count;
  freq_t             pulse_rate;
  logic              stage_mode;
  assign spd        = speed_source_t'(speed_reference_source);
  assign stage_mode = (spd == SPD_STAGE);
  assign up_sum     = {1'b0, digital_frequency} + {1'b0, step_size};

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      digital_frequency <= 16'h0000;
      store_request     <= 1'b0;
    end else if (ce) begin
      store_request <= 1'b0;
      if (wr_en && paddr == `ADDR_DIGITAL_FREQ && pstrb[0] && pstrb[1]) begin
        digital_frequency <= pwdata[15:0];
        store_request     <= (spd == SPD_DIGITAL_KEEP);
      end else if (!stage_mode && up_request && !down_request) begin
        digital_frequency <= (up_sum > {1'b0, max_frequency}) ? max_frequency : up_sum[15:0];
        store_request     <= (spd == SPD_DIGITAL_KEEP);
      end else if (!stage_mode && down_request && !up_request) begin
        digital_frequency <= (digital_frequency > step_size) ?
                             digital_frequency - step_size : 16'h0000;
        store_request     <= (spd == SPD_DIGITAL_KEEP);
      end
    end
  end
  assign store_value = digital_frequency;

  // trim lives only in flip-flops, so it is gone after power loss
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      trim <= 18'sd0;
    end else if (ce && stage_mode) begin
      if (up_request && !down_request) trim <= trim + $signed({2'b00, step_size});
      else if (down_request && !up_request) trim <= trim - $signed({2'b00, step_size});
    end
  end
  assign stage_sum = $signed({2'b00, stage_frequency}) + trim;

  // rate is edges per gate window; only valid with the pulse function on input 0
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gate_count  <= 32'h0000_0000;
      pulse_count <= 16'h0000;
      pulse_rate  <= 16'h0000;
    end else if (ce) begin
      if (gate_count >= 32'(PULSE_GATE_CYCLES - 1)) begin
        gate_count  <= 32'h0000_0000;
        pulse_rate  <= pulse_count;
        pulse_count <= 16'h0000;
      end else begin
        gate_count <= gate_count + 32'h0000_0001;
        if (terminals[0] && !terminals_prev[0] && pulse_count != 16'hFFFF
            && first_terminal_function == 5'(`PULSE_FUNCTION))
          pulse_count <= pulse_count + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference arithmetic
  logic signed [20:0] prod1;
  logic signed [20:0] prod2;
  logic signed [20:0] mix;
  logic [11:0]        analog_sel;
  logic [27:0]        analog_scaled;
  logic [7:0]         binary_value;
  logic [23:0]        binary_scaled;
  freq_t              next_reference;

  assign prod1 = $signed({9'h000, first_analog_channel}) * $signed({14'h0000, first_analog_gain});
  always_comb begin
    prod2 = $signed({9'h000, second_analog_channel}) * $signed({14'h0000, second_analog_gain});
    mix   = 21'sd0;
    if (spd == SPD_OFFSET)
      prod2 = ($signed({9'h000, second_analog_channel}) - 21'sd`HALF_SCALE_CODE)
            * $signed({14'h0000, second_analog_gain});
    unique case (spd)
      SPD_SUM, SPD_OFFSET: mix = (prod1 + prod2) / 21'sd10;
      SPD_DIFF:            mix = (prod1 - prod2) / 21'sd10;
      default:             mix = 21'sd0;
    endcase
  end

  always_comb begin
    analog_sel = 12'h000;
    unique case (spd)
      SPD_ANALOG1: analog_sel = first_analog_channel;
      SPD_ANALOG2: analog_sel = second_analog_channel;
      SPD_KNOB:    analog_sel = panel_knob_voltage;
      default:     analog_sel = (mix < 21'sd0) ? 12'h000 :
                                (mix > 21'sd4095) ? 12'hFFF : mix[11:0];
    endcase
  end
  assign analog_scaled = {16'h0000, analog_sel} * {12'h000, max_frequency};
  assign binary_value  = terminals & binary_mask;
  assign binary_scaled = ({16'h0000, binary_value} * {8'h00, max_frequency}) / 24'd255;

  always_comb begin
    next_reference = 16'h0000;
    unique case (spd)
      SPD_DIGITAL, SPD_DIGITAL_KEEP: next_reference = digital_frequency;
      SPD_STAGE:  next_reference = (stage_sum < 18'sd0) ? 16'h0000 :
                                   (stage_sum > $signed({2'b00, max_frequency})) ?
                                   max_frequency : stage_sum[15:0];
      SPD_ANALOG1, SPD_ANALOG2, SPD_SUM, SPD_DIFF, SPD_OFFSET, SPD_KNOB:
        next_reference = analog_scaled[27:12];
      SPD_PULSE:  next_reference = (pulse_rate > max_frequency) ? max_frequency : pulse_rate;
      SPD_BINARY: next_reference = binary_scaled[15:0];
      default:    next_reference = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      speed_reference <= 16'h0000;
    end else if (ce) begin
      speed_reference <= next_reference;
    end
  end

endmodule : drive_command_source_select
`default_nettype wire

// ==== common/drive_select_consts.svh ====
`ifndef DRIVE_SELECT_CONSTS_SVH
`define DRIVE_SELECT_CONSTS_SVH
`define CLK_PERIOD_NS      5
`define PULSE_GATE_NS      1000000
`define ADDR_SELECT        12'h000
`define ADDR_TERM_MAP      12'h004
`define ADDR_GAINS         12'h008
`define ADDR_MAX_FREQ      12'h00C
`define ADDR_DIGITAL_FREQ  12'h010
`define ADDR_REMOTE_CMD    12'h014
`define ADDR_STATUS        12'h018
`define ADDR_STEP          12'h01C
`define CMD_SRC_MAX        2
`define STOP_SCOPE_MAX     2
`define WIRING_MAX         4
`define SPEED_SRC_MAX      10
`define GAIN_MAX           100
`define PULSE_FUNCTION     23
`define HALF_SCALE_CODE    2048
`define MAX_FREQ_RESET     16'h1388
`define STEP_RESET         16'h0064
`define GAIN_RESET         7'd10
`define STATUS_ESTOP_BIT   2
`endif

// ==== common/drive_select_pkg.sv ====
`default_nettype none
package drive_select_pkg;
  typedef logic [15:0] freq_t;
  typedef enum logic [1:0] {SRC_KEYPAD, SRC_TERMINAL, SRC_REMOTE, SRC_ILLEGAL} cmd_source_t;
  typedef enum logic [3:0] {
    SPD_DIGITAL, SPD_DIGITAL_KEEP, SPD_STAGE, SPD_ANALOG1, SPD_ANALOG2, SPD_SUM,
    SPD_DIFF, SPD_PULSE, SPD_BINARY, SPD_OFFSET, SPD_KNOB, SPD_R11, SPD_R12,
    SPD_R13, SPD_R14, SPD_R15
  } speed_source_t;
endpackage : drive_select_pkg
`default_nettype wire

// ==== tb/terminal_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module terminal_panel_model (
  input  wire logic       core_clk,
  input  wire logic       ahead,
  input  wire logic       backward,
  input  wire logic       hold,
  input  wire logic [7:0] code,
  output logic      [7:0] programmable_inputs
);
  // contacts on inputs 0..2, binary code ORed onto all eight inputs
  always_ff @(posedge core_clk) begin
    programmable_inputs <= code | {5'h00, hold, backward, ahead};
  end
endmodule : terminal_panel_model
`default_nettype wire

// ==== tb/drive_command_source_select_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module drive_select_checker (
  input wire logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        stop_key, drive_running, drive_stalling, run_command,
  input wire logic        ramp_stop, immediate_stop, emergency_stop_error_code,
  input wire logic [15:0] speed_reference,
  input wire logic        store_request
);
  logic [1:0] cmd;
  logic [1:0] scope;
  logic [3:0] spd;
  wire        wr  = psel && penable && pready && pwrite;
  wire        hit = stop_key && drive_running;
  // mirror of the command source, stop scope and speed source fields, out-of-range fields ignored
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmd <= '0;
      scope <= '0;
      spd <= '0;
    end else if (wr && paddr == 12'h000) begin
      if (pwdata[1:0] <= 2'h2) cmd <= pwdata[1:0];
      if (pwdata[3:2] <= 2'h2) scope <= pwdata[3:2];
      if (pwdata[11:8] <= 4'ha) spd <= pwdata[11:8];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_keypad_ramp: assert property (cmd == 0 && !drive_stalling && hit |=> ramp_stop && !run_command)
    else $error("keypad stop did not ramp");
  a_scope0_quiet: assert property (scope == 0 && cmd != 0 && !drive_stalling && hit
    |=> !ramp_stop && !immediate_stop) else $error("stop key acted outside keypad");
  a_scope1_hard: assert property (scope == 1 && cmd != 0 && hit
    |=> immediate_stop && emergency_stop_error_code) else $error("no hard stop");
  a_scope2_ramp: assert property (scope == 2 && cmd == 2 && !drive_stalling && hit
    |=> ramp_stop) else $error("remote stop did not ramp");
  a_stall_hard: assert property (hit && drive_stalling
    |=> immediate_stop && emergency_stop_error_code && !run_command)
    else $error("stall stop not immediate");
  a_estop_sticky: assert property (emergency_stop_error_code
    && !(wr && paddr == 12'h018 && pwdata[2]) |=> emergency_stop_error_code)
    else $error("error flag dropped");
  a_unmapped_err: assert property (psel && penable && paddr[11:5] != 0 |-> pslverr)
    else $error("unmapped access not refused");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !run_command && !ramp_stop
    && !emergency_stop_error_code && speed_reference == 16'h0000)
    else $error("outputs not cleared in reset");
  a_store_keep: assert property (spd != 1 && $past(spd) != 1 |-> !store_request)
    else $error("store outside keep source");
  c_ramp: cover property (ramp_stop);
  c_hard: cover property (immediate_stop);
  c_store: cover property (store_request);
endmodule : drive_select_checker
bind drive_command_source_select drive_select_checker i_chk (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
  .stop_key(stop_key), .drive_running(drive_running), .drive_stalling(drive_stalling),
  .run_command(run_command), .ramp_stop(ramp_stop), .immediate_stop(immediate_stop),
  .emergency_stop_error_code(emergency_stop_error_code),
  .speed_reference(speed_reference), .store_request(store_request));
`default_nettype wire

// ==== tb/drive_command_source_select_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "drive_select_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module drive_command_source_select_bench import drive_select_pkg::*; ;
  localparam int MAXF = `MAX_FREQ_RESET;
  logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0, a1 = '0, a2 = '0, knob = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic kr = 1'b0, sk = 1'b0, run_in = 1'b0, stall = 1'b0, ahead = 1'b0, back = 1'b0;
  logic err, pready, pslverr, run_cmd, rev_cmd, ramp, hard, estop, store;
  logic [7:0] code = '0;
  logic [7:0] pins;
  logic [15:0] spd_ref, lf = 16'h000f, dig = '0, sv;
  logic up = 1'b0, dn = 1'b0, hold = 1'b1;
  logic [3:0] ev;
  int failures = 0, num_checks = 0, s;
  int srcs[9] = '{0, 1, 3, 4, 5, 6, 8, 9, 10};
  initial forever #2.5 core_clk = ~core_clk;
  drive_command_source_select #(.PULSE_GATE_CYCLES(50)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .programmable_inputs(pins), .keypad_run_key(kr),
    .stop_key(sk), .up_request(up), .down_request(dn), .drive_running(run_in),
    .drive_stalling(stall), .stage_frequency(16'h0000), .first_analog_channel(a1),
    .second_analog_channel(a2), .panel_knob_voltage(knob), .run_command(run_cmd),
    .reverse_command(rev_cmd), .ramp_stop(ramp), .immediate_stop(hard),
    .emergency_stop_error_code(estop), .speed_reference(spd_ref), .store_request(store),
    .store_value(sv));
  terminal_panel_model i_panel (.core_clk(core_clk), .ahead(ahead), .backward(back),
    .hold(hold), .code(code), .programmable_inputs(pins));
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  function automatic freq_t want(int src);
    int v;
    case (src)
      3: v = a1;
      4: v = a2;
      10: v = knob;
      5: v = a1 + a2;
      6: v = a1 - a2;
      9: v = a1 + a2 - 2048;
      8: return freq_t'(int'(code & 8'hf8) * MAXF / 255);
      default: return dig;
    endcase
    // compound sums clip before scaling
    if (v < 0) v = 0;
    if (v > 4095) v = 4095;
    return freq_t'(v * MAXF >> 12);
  endfunction : want
  task automatic complete_run();
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin failures++; complete_run(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic stop_press();
    sk <= 1'b1;
    @(posedge core_clk) sk <= 1'b0;
    @(negedge core_clk) ev = {ramp, hard, estop, run_cmd};
    @(posedge core_clk);
  endtask : stop_press
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    apb(0, 12'h000, '0); `CHK(rd, 32'h0000_0000)
    apb(0, 12'h00c, '0); `CHK(rd[15:0], `MAX_FREQ_RESET)
    apb(0, 12'h020, '0); `CHK(err, 1'b1)
    apb(1, 12'h000, 32'h0000_0b03); apb(0, 12'h000, '0); `CHK(rd, 32'h0000_0000)
    apb(1, 12'h004, 32'h00f8_0210);
    for (int d = 0; d < 2; d++) begin
      apb(1, 12'h000, 32'(d) << 7);
      kr <= 1'b1;
      @(posedge core_clk) kr <= 1'b0;
      repeat (2) @(posedge core_clk);
      `CHK(run_cmd, 1'b1)
      `CHK(rev_cmd, d[0])
      run_in <= 1'b1;
      stop_press(); `CHK({ev[3], ev[0]}, 2'b10)
    end
    stall <= 1'b1;
    stop_press(); `CHK(ev[2:1], 2'b11)
    stall <= 1'b0;
    apb(1, 12'h018, 32'h0000_0004); apb(0, 12'h018, '0); `CHK(rd[2], 1'b0)
    apb(1, 12'h000, 32'h0000_0015); ahead <= 1'b1; back <= 1'b1;
    repeat (10) @(posedge core_clk);
    `CHK({run_cmd, rev_cmd}, 2'b11)
    stop_press(); `CHK({ev[2], ev[0]}, 2'b10)
    apb(0, 12'h018, '0); `CHK(rd[2], 1'b1)
    ahead <= 1'b0; back <= 1'b0;
    apb(1, 12'h018, 32'h0000_0004); apb(1, 12'h000, 32'h0000_0002);
    apb(1, 12'h014, 32'h0000_0003); @(posedge core_clk); `CHK({run_cmd, rev_cmd}, 2'b11)
    stop_press(); `CHK({ev[3:2], ev[0]}, 3'b001)
    apb(1, 12'h000, 32'h0000_000a); stop_press(); `CHK(ev[3], 1'b1)
    apb(1, 12'h014, '0); run_in <= 1'b0;
    // first pass at full scale hits the clip corners
    for (int i = 0; i < 27; i++) begin
      s = srcs[i % 9];
      lf = nxt(lf); a1 <= (i < 9) ? 12'hfff : lf[11:0];
      lf = nxt(lf); a2 <= (i < 9) ? 12'hfff : lf[11:0];
      lf = nxt(lf); knob <= lf[11:0]; code <= lf[15:8];
      lf = nxt(lf); dig = 16'(int'(lf) % MAXF);
      apb(1, 12'h010, {16'h0000, dig}); apb(1, 12'h000, 32'(s) << 8);
      repeat (10) @(posedge core_clk);
      `CHK(spd_ref, want(s))
    end
    code <= 8'h00; apb(1, 12'h000, 32'h0000_0021); repeat (6) @(posedge core_clk);
    ahead <= 1'b1; repeat (8) @(posedge core_clk);
    `CHK({run_cmd, rev_cmd}, 2'b10)
    hold <= 1'b0; repeat (8) @(posedge core_clk);
    `CHK(run_cmd, 1'b0)
    apb(1, 12'h010, 32'h0000_0100); apb(1, 12'h000, 32'h0000_0100);
    up <= 1'b1; @(posedge core_clk) up <= 1'b0; repeat (2) @(posedge core_clk);
    `CHK({sv, spd_ref}, {2{16'h0100 + `STEP_RESET}})
    dn <= 1'b1; @(posedge core_clk) dn <= 1'b0; @(posedge core_clk);
    `CHK(sv, 16'h0100)
    complete_run();
  end
endmodule : drive_command_source_select_bench
`default_nettype wire
